// ===== common/fpib_defs.svh
`ifndef FPIB_DEFS_SVH
`define FPIB_DEFS_SVH

`define FPIB_ADDR_W          32
`define FPIB_DATA_W          32
`define FPIB_CACHE_BASE      32'h0800_0000
`define FPIB_CACHE_LAST      32'h080f_ffff
`define FPIB_NC_BASE         32'h0c00_0000
`define FPIB_NC_LAST         32'h0c0f_ffff
`define FPIB_ROM_BASE        32'h0000_0000
`define FPIB_ROM_LAST        32'h0000_3fff
`define FPIB_WORD_LSB        2
`define FPIB_DEF_ENTRIES     8

`endif

// ===== common/fpib_pkg.sv
package fpib_pkg;

  typedef enum logic [1:0]
  {
    FPIB_REG_OTHER  = 2'b00,
    FPIB_REG_CACHE  = 2'b01,
    FPIB_REG_NCACHE = 2'b10,
    FPIB_REG_ROM    = 2'b11
  } fpib_region_t;

  // Request from the core towards the buffer
  typedef struct packed
  {
    logic        valid;
    logic        isFetch;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpib_req_t;

  // Answer back to the core
  typedef struct packed
  {
    logic        valid;
    logic        fromBuffer;
    logic [31:0] rdata;
  } fpib_rsp_t;

  typedef enum logic [1:0]
  {
    FPIB_IDLE = 2'b00,
    FPIB_MEM  = 2'b01,
    FPIB_HIT  = 2'b10
  } fpib_state_t;

endpackage : fpib_pkg

// ===== hdl/fpib_region_decode.sv
`timescale 1ns/10ps
`include "fpib_defs.svh"

module fpib_region_decode
  import fpib_pkg::*;
(
  input  wire logic [31:0] addr,
  output fpib_region_t     region
);

  always_comb
  begin
    if (addr >= `FPIB_CACHE_BASE && addr <= `FPIB_CACHE_LAST)
      region = FPIB_REG_CACHE;
    else if (addr >= `FPIB_NC_BASE && addr <= `FPIB_NC_LAST)
      region = FPIB_REG_NCACHE;
    else if (addr <= `FPIB_ROM_LAST)
      region = FPIB_REG_ROM;
    else
      region = FPIB_REG_OTHER;
  end

endmodule : fpib_region_decode

// ===== hdl/flash_prefetch_instruction_buffer.sv
`timescale 1ns/10ps
`include "fpib_defs.svh"

// Function
// - Fetches in the cacheable flash window are eligible for the buffer.
// - Fetches to the non-cacheable alias or ROM bypass the buffer.
// - A cacheable fetch that hits a valid entry is served without memory.
// - A cacheable hit right after a non-cacheable fetch returns true data.
// - Data reads and writes never use or alter the buffer.
// - Fetches to other regions such as SRAM never involve the buffer.
// - With instruction_buffer_bypass set, cacheable fetches go to memory.

module flash_prefetch_instruction_buffer
  import fpib_pkg::*;
#(
  parameter int ENTRIES = `FPIB_DEF_ENTRIES
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic instructionBufferBypass,
  input  wire logic invalidate,
  input  fpib_req_t coreReq,
  output logic      coreReady,
  output fpib_rsp_t coreRsp,
  output fpib_req_t memReq,
  input  wire logic memReady,
  input  wire logic memRspValid,
  input  wire logic [31:0] memRdata
);

  localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam int TW = 32 - IW - `FPIB_WORD_LSB;

  // ----------------------------------------------------------------
  // Index and tag
  // ----------------------------------------------------------------
  function automatic logic [IW-1:0] idxOf(input logic [31:0] a);
    idxOf = a[`FPIB_WORD_LSB +: IW];
  endfunction : idxOf

  function automatic logic [TW-1:0] tagOf(input logic [31:0] a);
    tagOf = a[31 -: TW];
  endfunction : tagOf

  fpib_region_t reqRegion;

  fpib_region_decode u_dec
  (
    .addr   (coreReq.addr),
    .region (reqRegion)
  );

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0]   dataMem  [ENTRIES];
  logic [TW-1:0] tagMem   [ENTRIES];
  logic [ENTRIES-1:0] validBits;
  logic [ENTRIES-1:0] next_validBits;

  fpib_state_t   state;
  fpib_state_t   next_state;
  logic [31:0]   pendAddr;
  logic [31:0]   next_pendAddr;
  logic          pendAlloc;
  logic          next_pendAlloc;
  fpib_req_t     next_memReq;
  fpib_rsp_t     next_coreRsp;
  logic          next_coreReady;
  logic          writeEntry;

  logic accept;
  logic cacheable;
  logic hit;

  assign accept    = coreReq.valid && coreReady;
  // Only instruction fetches qualify; data traffic never touches the array
  assign cacheable = coreReq.isFetch && !coreReq.write
                     && reqRegion == FPIB_REG_CACHE
                     && !instructionBufferBypass;
  assign hit = cacheable && validBits[idxOf(coreReq.addr)]
               && tagMem[idxOf(coreReq.addr)] == tagOf(coreReq.addr);

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state     = state;
    next_pendAddr  = pendAddr;
    next_pendAlloc = pendAlloc;
    next_memReq    = memReq;
    next_coreRsp   = '0;
    next_coreReady = coreReady;
    next_validBits = validBits;
    writeEntry     = 1'b0;
    case (state)
      FPIB_IDLE:
      begin
        if (accept)
        begin
          next_coreReady = 1'b0;
          if (hit)
          begin
            // Data comes straight from the array, independent of the
            // region of the previous fetch, so no stale zero word leaks
            next_coreRsp.valid      = 1'b1;
            next_coreRsp.fromBuffer = 1'b1;
            next_coreRsp.rdata      = dataMem[idxOf(coreReq.addr)];
            next_state              = FPIB_HIT;
          end
          else
          begin
            next_memReq    = coreReq;
            next_pendAddr  = coreReq.addr;
            next_pendAlloc = cacheable;
            next_state     = FPIB_MEM;
          end
        end
      end
      FPIB_MEM:
      begin
        if (memReq.valid && memReady)
          next_memReq.valid = 1'b0;
        if (memRspValid && !(memReq.valid && !memReady))
        begin
          next_coreRsp.valid = 1'b1;
          next_coreRsp.rdata = memRdata;
          writeEntry         = pendAlloc;
          if (pendAlloc)
            next_validBits[idxOf(pendAddr)] = 1'b1;
          next_pendAlloc = 1'b0;
          next_coreReady = 1'b1;
          next_state     = FPIB_IDLE;
        end
      end
      FPIB_HIT:
      begin
        next_coreReady = 1'b1;
        next_state     = FPIB_IDLE;
      end
      default:
      begin
        next_state     = FPIB_IDLE;
        next_coreReady = 1'b1;
      end
    endcase
    if (invalidate)
      next_validBits = '0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= FPIB_IDLE;
      pendAddr  <= '0;
      pendAlloc <= 1'b0;
      memReq    <= '0;
      coreRsp   <= '0;
      coreReady <= 1'b1;
      validBits <= '0;
    end
    else
    begin
      state     <= next_state;
      pendAddr  <= next_pendAddr;
      pendAlloc <= next_pendAlloc;
      memReq    <= next_memReq;
      coreRsp   <= next_coreRsp;
      coreReady <= next_coreReady;
      validBits <= next_validBits;
    end
  end

  // ----------------------------------------------------------------
  // Array write, no reset needed since valid bits guard it
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (writeEntry)
    begin
      dataMem[idxOf(pendAddr)] <= memRdata;
      tagMem[idxOf(pendAddr)]  <= tagOf(pendAddr);
    end
  end

endmodule : flash_prefetch_instruction_buffer

// ===== bench/fpib_props.sv
`timescale 1ns/10ps
`include "fpib_defs.svh"
// ---
// Port checks
// ---
module fpib_props
  import fpib_pkg::*;
#(parameter int ENTRIES = `FPIB_DEF_ENTRIES)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instructionBufferBypass,
  input wire logic invalidate,
  input fpib_req_t coreReq,
  input wire logic coreReady,
  input fpib_rsp_t coreRsp,
  input fpib_req_t memReq,
  input wire logic memReady,
  input wire logic memRspValid,
  input wire logic [31:0] memRdata
);
  wire logic take = coreReq.valid && coreReady;
  wire logic cach = coreReq.isFetch && !coreReq.write &&
    !instructionBufferBypass &&
    coreReq.addr inside {[`FPIB_CACHE_BASE:`FPIB_CACHE_LAST]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  uncached_to_mem_a: assert property
    (take && !cach |=> memReq.valid && !coreRsp.valid) else $error("no mem");
  one_path_a: assert property
    (take |=> memReq.valid != coreRsp.valid) else $error("two paths");
  hit_cause_a: assert property
    (coreRsp.valid && coreRsp.fromBuffer |-> $past(cach)) else $error("hit");
  mem_hold_a: assert property
    (memReq.valid && !memReady |=> $stable(memReq)) else $error("unstable");
  rsp_pulse_a: assert property
    (coreRsp.valid |=> !coreRsp.valid) else $error("long answer");
  busy_take_a: assert property
    (take |=> !coreReady) else $error("ready after take");
  miss_data_a: assert property
    (memRspValid && !coreReady && !memReq.valid |=> coreRsp.valid &&
     !coreRsp.fromBuffer && coreRsp.rdata == $past(memRdata))
    else $error("miss data");
  answer_bound_a: assert property
    (take |-> ##[1:40] coreRsp.valid) else $error("no answer");
endmodule : fpib_props
bind flash_prefetch_instruction_buffer fpib_props #(.ENTRIES(ENTRIES)) u_p
(
  .clk                     (clk),
  .rst_n                   (rst_n),
  .instructionBufferBypass (instructionBufferBypass),
  .invalidate              (invalidate),
  .coreReq                 (coreReq),
  .coreReady               (coreReady),
  .coreRsp                 (coreRsp),
  .memReq                  (memReq),
  .memReady                (memReady),
  .memRspValid             (memRspValid),
  .memRdata                (memRdata)
);

// ===== bench/fpib_mem_model.sv
`timescale 1ns/10ps
// ---
// Flash side model
// ---
module fpib_mem_model
  import fpib_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   slow,
  input  fpib_req_t   memReq,
  output logic        memReady,
  output logic        memRspValid,
  output logic [31:0] memRdata
);
  logic [2:0] waitCnt;
  wire logic acc = memReq.valid && memReady;
  // Idle data flips each cycle so a stale word never looks valid
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {memReady, memRspValid, waitCnt} <= '0;
      memRdata <= '0;
    end
    else
    begin
      memRspValid <= acc;
      memRdata <= acc ? ~memReq.addr : ~memRdata;
      waitCnt <= memReq.valid && !acc ? waitCnt + 3'h1 : 3'h0;
      memReady <= memReq.valid && !acc && waitCnt >= (slow ? 3'h3 : 3'h0);
    end
endmodule : fpib_mem_model

// ===== bench/flash_prefetch_instruction_buffer_bench.sv
`timescale 1ns/10ps
// ---
// Core side driver
// ---
module flash_prefetch_instruction_buffer_bench import fpib_pkg::*;;
  logic clk = 0, rst_n = 0, instructionBufferBypass = 0;
  logic invalidate = 0, slow = 0, coreReady, memReady, memRspValid;
  logic [31:0] memRdata;
  fpib_req_t coreReq = '0, memReq;
  fpib_rsp_t coreRsp;
  int errors = 0, checked = 0, cycles = 0;
  always #20 clk = ~clk;
  flash_prefetch_instruction_buffer dut
  (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .instructionBufferBypass (instructionBufferBypass),
    .invalidate              (invalidate),
    .coreReq                 (coreReq),
    .coreReady               (coreReady),
    .coreRsp                 (coreRsp),
    .memReq                  (memReq),
    .memReady                (memReady),
    .memRspValid             (memRspValid),
    .memRdata                (memRdata)
  );
  fpib_mem_model mem
  (
    .clk         (clk),
    .rst_n       (rst_n),
    .slow        (slow),
    .memReq      (memReq),
    .memReady    (memReady),
    .memRspValid (memRspValid),
    .memRdata    (memRdata)
  );
  task automatic results;
    $display("%0d checked, %0d errors", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic check(input logic [33:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  // Read data of a write is unspecified, so it is masked
  task automatic xfer(input logic f, w, input logic [31:0] a, input logic h);
    int n;
    n = 0;
    coreReq = '{1'b1, f, w, a, ~a};
    while (coreReady !== 1'b1 && n++ < 50) @(negedge clk);
    @(negedge clk);
    coreReq.valid = 1'b0;
    while (coreRsp.valid !== 1'b1 && n++ < 99) @(negedge clk);
    check({coreRsp.valid, coreRsp.fromBuffer, w ? 32'h0 : coreRsp.rdata},
      {1'b1, h, w ? 32'h0 : ~a});
    @(negedge clk);
  endtask : xfer
  task automatic t_hit;
    xfer(1, 0, 32'h0800_0010, 0);
    xfer(1, 0, 32'h0800_0010, 1);
    xfer(1, 0, 32'h0800_0030, 0);
    xfer(1, 0, 32'h0800_0010, 0);
    $display("t_hit done");
  endtask : t_hit
  task automatic t_alias;
    xfer(1, 0, 32'h0c00_0010, 0);
    xfer(1, 0, 32'h0800_0010, 1);
    xfer(1, 0, 32'h0000_0000, 0);
    xfer(1, 0, 32'h0800_0010, 1);
    xfer(1, 0, 32'h0000_0000, 0);
    xfer(1, 0, 32'h0c0f_fffc, 0);
    xfer(1, 0, 32'h0c0f_fffc, 0);
    xfer(1, 0, 32'h0800_0010, 1);
    $display("t_alias done");
  endtask : t_alias
  task automatic t_data;
    // Own index, so the entry of the earlier fetch stays in place
    xfer(0, 0, 32'h0800_0048, 0);
    xfer(1, 0, 32'h0800_0048, 0);
    xfer(0, 0, 32'h0800_0048, 0);
    // Same index, other tag: an allocating write would evict the entry
    xfer(0, 1, 32'h0800_0030, 0);
    xfer(1, 0, 32'h0800_0010, 1);
    xfer(1, 0, 32'h2000_0000, 0);
    xfer(1, 0, 32'h2000_0000, 0);
    $display("t_data done");
  endtask : t_data
  task automatic t_bypass;
    slow = 1;
    instructionBufferBypass = 1;
    xfer(1, 0, 32'h0800_0010, 0);
    xfer(1, 0, 32'h0800_0070, 0);
    instructionBufferBypass = 0;
    // Bypass keeps old entries, so hits resume once it is cleared
    xfer(1, 0, 32'h0800_0010, 1);
    xfer(1, 0, 32'h0800_0070, 0);
    invalidate = 1;
    @(negedge clk);
    invalidate = 0;
    // Would hit if invalidate had left the fresh entry valid
    xfer(1, 0, 32'h0800_0070, 0);
    $display("t_bypass done");
  endtask : t_bypass
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t_hit;
    t_alias;
    t_data;
    t_bypass;
    results;
  end
  always @(posedge clk)
    if (++cycles == 3000)
    begin
      errors++;
      results;
    end
endmodule : flash_prefetch_instruction_buffer_bench
